// ===== hdl/eag_defines.svh
// constants for the effective address generator
// Overview of operation
// - register indirect via any address register: plain, postinc, predec, disp, index
// - 8 or 16 bit short displacement is sign-extended and added
// - index value is scaled by 1, 2, 4 or 8 before adding
// - index from any data or address register, word or long size
// - base displacement of 16 or 32 bits is added
// - outer displacement is added only after the pointer fetch
// - memory indirect reads a long pointer; index before or after that read
// - pc relative modes offer the same options with pc as base, except postinc and predec, which always use the address register
// - absolute address taken from instruction stream, short or long
// - immediate operand of 8, 16 or 32 bits taken from the stream
// - register direct selects one of eight data or address registers
`ifndef EAG_DEFINES_SVH
`define EAG_DEFINES_SVH
`define EAG_ADDR_W      32
`define EAG_NUM_REGS    8
`define EAG_SEL_W       3
`define EAG_ADDR_RST    32'h0000_0000
`define EAG_SCALE_W     2
`define EAG_SIZE_W      2
`endif

// ===== hdl/eag_pkg.sv
// types for the effective address generator
package eag_pkg;
    typedef enum logic [3:0] {
        EAG_MODE_DREG     = 4'h0,
        EAG_MODE_AREG     = 4'h1,
        EAG_MODE_IND      = 4'h2,
        EAG_MODE_POSTINC  = 4'h3,
        EAG_MODE_PREDEC   = 4'h4,
        EAG_MODE_DISP     = 4'h5,
        EAG_MODE_INDEX    = 4'h6,
        EAG_MODE_MEM_POST = 4'h7,
        EAG_MODE_MEM_PRE  = 4'h8,
        EAG_MODE_ABS_W    = 4'h9,
        EAG_MODE_ABS_L    = 4'hA,
        EAG_MODE_IMM      = 4'hB
    } eag_mode_e;
    typedef enum logic [1:0] {
        EAG_SZ_BYTE = 2'h0,
        EAG_SZ_WORD = 2'h1,
        EAG_SZ_LONG = 2'h2
    } eag_size_e;
    typedef enum logic [1:0] {
        EAG_ST_IDLE  = 2'b00,
        EAG_ST_FETCH = 2'b01,
        EAG_ST_DONE  = 2'b10
    } eag_state_e;
endpackage

// ===== hdl/eag_index_unit.sv
// scaled index operand former
`timescale 1ns/10ps
`include "eag_defines.svh"
module eag_index_unit
    import eag_pkg::*;
#(
    parameter int ADDR_W = `EAG_ADDR_W
) (
    // index source and format
    input  wire logic [ADDR_W-1:0] index_val_i,
    input  wire logic              index_long_i,
    input  wire logic [1:0]        index_scale_i,
    // scaled result
    output logic      [ADDR_W-1:0] index_scaled_o
);
    initial begin
        if (ADDR_W != 32) $error("eag_index_unit supports 32-bit only");
    end
    logic [ADDR_W-1:0] ext;
    // word index is sign-extended from its low half
    assign ext = index_long_i ? index_val_i
               : {{(ADDR_W-16){index_val_i[15]}}, index_val_i[15:0]};
    // shift drops carried-out bits, so the sum wraps
    assign index_scaled_o = ext << index_scale_i;
endmodule // eag_index_unit

// ===== hdl/eag_effective_address.sv
// effective address generator datapath and sequencer
`timescale 1ns/10ps
`include "eag_defines.svh"
module eag_effective_address
    import eag_pkg::*;
#(
    parameter int ADDR_W = `EAG_ADDR_W
) (
    // clock and reset
    input  wire logic              clk_i,
    input  wire logic              rstn_i,
    // request from the decoder
    input  wire logic              req_valid_i,
    output logic                   req_ready_o,
    input  wire logic [3:0]        mode_i,
    input  wire logic              pc_base_i,
    input  wire logic [1:0]        op_size_i,
    input  wire logic [2:0]        addr_reg_sel_i,
    input  wire logic [2:0]        data_reg_sel_i,
    input  wire logic [2:0]        index_reg_sel_i,
    input  wire logic              index_is_addr_i,
    input  wire logic              index_long_i,
    input  wire logic [1:0]        index_scale_i,
    input  wire logic              short_disp_8b_i,
    input  wire logic [15:0]       short_displacement_i,
    input  wire logic              base_disp_long_i,
    input  wire logic [31:0]       base_displacement_i,
    input  wire logic              outer_disp_long_i,
    input  wire logic [31:0]       outer_displacement_i,
    input  wire logic [31:0]       ext_word_i,
    input  wire logic [ADDR_W-1:0] pc_i,
    // register file
    input  wire logic [ADDR_W-1:0] data_regs_i [`EAG_NUM_REGS],
    input  wire logic [ADDR_W-1:0] addr_regs_i [`EAG_NUM_REGS],
    output logic                   areg_we_o,
    output logic [2:0]             areg_wsel_o,
    output logic [ADDR_W-1:0]      areg_wdata_o,
    // memory pointer fetch
    output logic                   mem_req_o,
    output logic [ADDR_W-1:0]      mem_addr_o,
    input  wire logic              mem_ack_i,
    input  wire logic [31:0]       mem_rdata_i,
    // result
    output logic                   res_valid_o,
    output logic                   res_is_operand_o,
    output logic [ADDR_W-1:0]      res_value_o
);
    initial begin
        if (ADDR_W != 32) $error("eag_effective_address needs ADDR_W 32");
    end

    function automatic logic [ADDR_W-1:0] sext16(input logic [15:0] v);
        return {{(ADDR_W-16){v[15]}}, v};
    endfunction
    function automatic logic [ADDR_W-1:0] size_bytes(input logic [1:0] s);
        return (s == EAG_SZ_BYTE) ? 32'h0000_0001
             : (s == EAG_SZ_WORD) ? 32'h0000_0002 : 32'h0000_0004;
    endfunction

    eag_state_e        state_reg;
    logic [ADDR_W-1:0] hold_index_reg;
    logic [ADDR_W-1:0] hold_outer_reg;
    logic              hold_post_reg;

    logic [ADDR_W-1:0] base, idx_raw, idx_scaled, sdisp, bdisp, odisp;
    logic [ADDR_W-1:0] abase, sum_disp, sum_idx, sum_mem, step;

    eag_index_unit #(.ADDR_W(ADDR_W)) u_index (
        .index_val_i    (idx_raw),
        .index_long_i   (index_long_i),
        .index_scale_i  (index_scale_i),
        .index_scaled_o (idx_scaled)
    );

    assign abase   = addr_regs_i[addr_reg_sel_i];
    assign base    = pc_base_i ? pc_i : abase;
    assign idx_raw = index_is_addr_i ? addr_regs_i[index_reg_sel_i]
                   : data_regs_i[index_reg_sel_i];
    assign sdisp   = short_disp_8b_i
                   ? {{(ADDR_W-8){short_displacement_i[7]}},
                      short_displacement_i[7:0]}
                   : sext16(short_displacement_i);
    assign bdisp   = base_disp_long_i ? base_displacement_i
                   : sext16(base_displacement_i[15:0]);
    assign odisp   = outer_disp_long_i ? outer_displacement_i
                   : sext16(outer_displacement_i[15:0]);
    assign step    = size_bytes(op_size_i);
    assign sum_disp = base + sdisp;
    assign sum_idx  = base + sdisp + idx_scaled;
    // preindexed form folds the index in before the pointer read
    assign sum_mem  = base + bdisp
                    + ((mode_i == EAG_MODE_MEM_PRE) ? idx_scaled : '0);

    assign req_ready_o = (state_reg == EAG_ST_IDLE);

    logic accept;
    assign accept = req_valid_i && req_ready_o;

    // sequencer
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_reg <= EAG_ST_IDLE;
        end else begin
            case (state_reg)
                EAG_ST_IDLE: begin
                    if (accept && (mode_i == EAG_MODE_MEM_POST ||
                                   mode_i == EAG_MODE_MEM_PRE)) begin
                        state_reg <= EAG_ST_FETCH;
                    end else if (accept) begin
                        state_reg <= EAG_ST_DONE;
                    end
                end
                EAG_ST_FETCH: begin
                    if (mem_ack_i) begin
                        state_reg <= EAG_ST_DONE;
                    end
                end
                default: state_reg <= EAG_ST_IDLE;
            endcase
        end
    end

    // held terms for the post-fetch stage
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            hold_index_reg <= `EAG_ADDR_RST;
            hold_outer_reg <= `EAG_ADDR_RST;
            hold_post_reg  <= 1'b0;
        end else if (accept) begin
            hold_index_reg <= idx_scaled;
            hold_outer_reg <= odisp;
            hold_post_reg  <= (mode_i == EAG_MODE_MEM_POST);
        end
    end

    // pointer fetch port
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            mem_req_o  <= 1'b0;
            mem_addr_o <= `EAG_ADDR_RST;
        end else if (accept && (mode_i == EAG_MODE_MEM_POST ||
                                mode_i == EAG_MODE_MEM_PRE)) begin
            mem_req_o  <= 1'b1;
            mem_addr_o <= sum_mem;
        end else if (mem_ack_i) begin
            mem_req_o  <= 1'b0;
        end
    end

    // result and address register update
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            res_valid_o      <= 1'b0;
            res_is_operand_o <= 1'b0;
            res_value_o      <= `EAG_ADDR_RST;
            areg_we_o        <= 1'b0;
            areg_wsel_o      <= 3'h0;
            areg_wdata_o     <= `EAG_ADDR_RST;
        end else begin
            res_valid_o <= 1'b0;
            areg_we_o   <= 1'b0;
            if (state_reg == EAG_ST_FETCH && mem_ack_i) begin
                res_valid_o      <= 1'b1;
                res_is_operand_o <= 1'b0;
                // outer displacement only after the pointer arrives
                res_value_o <= mem_rdata_i + hold_outer_reg
                    + (hold_post_reg ? hold_index_reg : '0);
            end else if (accept && mode_i != EAG_MODE_MEM_POST &&
                         mode_i != EAG_MODE_MEM_PRE) begin
                res_valid_o      <= 1'b1;
                res_is_operand_o <= 1'b0;
                areg_wsel_o      <= addr_reg_sel_i;
                case (mode_i)
                    EAG_MODE_DREG: begin
                        res_is_operand_o <= 1'b1;
                        res_value_o <= data_regs_i[data_reg_sel_i];
                    end
                    EAG_MODE_AREG: begin
                        res_is_operand_o <= 1'b1;
                        res_value_o <= abase;
                    end
                    EAG_MODE_IND: res_value_o <= base;
                    EAG_MODE_POSTINC: begin
                        res_value_o  <= abase;
                        areg_we_o    <= 1'b1;
                        areg_wdata_o <= abase + step;
                    end
                    EAG_MODE_PREDEC: begin
                        res_value_o  <= abase - step;
                        areg_we_o    <= 1'b1;
                        areg_wdata_o <= abase - step;
                    end
                    EAG_MODE_DISP:   res_value_o <= sum_disp;
                    EAG_MODE_INDEX:  res_value_o <= sum_idx;
                    EAG_MODE_ABS_W: begin
                        res_value_o <= sext16(ext_word_i[15:0]);
                    end
                    EAG_MODE_ABS_L:  res_value_o <= ext_word_i;
                    EAG_MODE_IMM: begin
                        res_is_operand_o <= 1'b1;
                        res_value_o <= (op_size_i == EAG_SZ_BYTE)
                            ? {24'h00_0000, ext_word_i[7:0]}
                            : (op_size_i == EAG_SZ_WORD)
                            ? {16'h0000, ext_word_i[15:0]}
                            : ext_word_i;
                    end
                    default: res_value_o <= base;
                endcase
            end
        end
    end

    // a completed pointer read always yields a result in the next cycle
    a_fetch_done_ack:
        assert property (@(posedge clk_i) disable iff (!rstn_i)
        (state_reg == EAG_ST_FETCH && mem_ack_i) |=> res_valid_o)
        else $error("pointer fetch did not yield result");
    a_postinc_step:
        assert property (@(posedge clk_i) disable iff (!rstn_i)
        (accept && mode_i == EAG_MODE_POSTINC) |=>
        (areg_we_o && areg_wdata_o == res_value_o + $past(step)))
        else $error("postincrement step wrong");
    // write checked against the register before the access; result must equal the write
    a_predec_match:
        assert property (@(posedge clk_i) disable iff (!rstn_i)
        (accept && mode_i == EAG_MODE_PREDEC) |=>
        (areg_we_o && areg_wdata_o == $past(abase) - $past(step)
         && res_value_o == areg_wdata_o))
        else $error("predecrement address mismatch");
    a_disp_sum:
        assert property (@(posedge clk_i) disable iff (!rstn_i)
        (accept && mode_i == EAG_MODE_DISP) |=>
        res_value_o == $past(base) + $past(sdisp))
        else $error("displacement sum wrong");
    a_mem_issue:
        assert property (@(posedge clk_i) disable iff (!rstn_i)
        (accept && mode_i == EAG_MODE_MEM_PRE) |=>
        (mem_req_o && mem_addr_o == $past(base) + $past(bdisp)
         + $past(idx_scaled)))
        else $error("preindexed pointer address wrong");
    a_direct_op:
        assert property (@(posedge clk_i) disable iff (!rstn_i)
        (accept && mode_i == EAG_MODE_DREG) |=>
        (res_is_operand_o && !mem_req_o))
        else $error("register direct touched memory");
    a_abs_short:
        assert property (@(posedge clk_i) disable iff (!rstn_i)
        (accept && mode_i == EAG_MODE_ABS_W) |=>
        res_value_o[31:16] == {16{res_value_o[15]}})
        else $error("absolute short not sign-extended");
    a_pc_base:
        assert property (@(posedge clk_i) disable iff (!rstn_i)
        (accept && mode_i == EAG_MODE_IND && pc_base_i) |=>
        res_value_o == $past(pc_i))
        else $error("pc base not used");
endmodule // eag_effective_address

// ===== test/eag_mem_model.sv
// memory responder answering pointer fetches of the address generator
`timescale 1ns/10ps
module eag_mem_model (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rstn_i,
    // fetch request and answer
    input  wire logic        mem_req_i,
    input  wire logic [31:0] mem_addr_i,
    input  wire logic [2:0]  delay_i,
    output logic             mem_ack_o,
    output logic [31:0]      mem_rdata_o
);
    logic [2:0] wait_reg;

    // pointer follows from the address so the bench can predict it;
    // outside the ack cycle the data toggles so stale values never match
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            mem_ack_o   <= 1'b0;
            wait_reg    <= 3'h0;
            mem_rdata_o <= 32'h0000_0000;
        end else if (mem_req_i && !mem_ack_o && wait_reg == delay_i) begin
            mem_ack_o   <= 1'b1;
            wait_reg    <= 3'h0;
            mem_rdata_o <= {mem_addr_i[15:0], mem_addr_i[31:16]}
                           ^ 32'ha5a5_a5a5;
        end else begin
            mem_ack_o   <= 1'b0;
            mem_rdata_o <= ~mem_rdata_o;
            if (mem_req_i && !mem_ack_o) begin
                wait_reg <= wait_reg + 3'h1;
            end
        end
    end
endmodule // eag_mem_model

// ===== test/testbench.sv
// self-checking bench for the effective address generator
`timescale 1ns/10ps
`include "eag_defines.svh"
module testbench import eag_pkg::*;;
    logic        clk_i, rstn_i, req_valid_i, pc_base_i, index_is_addr_i;
    logic        index_long_i, short_disp_8b_i, base_disp_long_i;
    logic        outer_disp_long_i, mem_ack_i, req_ready_o, areg_we_o;
    logic        mem_req_o, res_valid_o, res_is_operand_o;
    logic [3:0]  mode_i;
    logic [1:0]  op_size_i, index_scale_i;
    logic [2:0]  addr_reg_sel_i, data_reg_sel_i, index_reg_sel_i;
    logic [2:0]  mem_delay, areg_wsel_o;
    logic [15:0] short_displacement_i;
    logic [31:0] base_displacement_i, outer_displacement_i, ext_word_i;
    logic [31:0] pc_i, mem_rdata_i, areg_wdata_o, mem_addr_o, res_value_o;
    logic [31:0] dr [`EAG_NUM_REGS];
    logic [31:0] ar [`EAG_NUM_REGS];
    logic [32:0] res_q [$];
    logic [34:0] wr_q [$];
    logic [31:0] rng;
    int          mismatches, num_checks, cycles;

    eag_effective_address u_eag_effective_address (
        .clk_i(clk_i), .rstn_i(rstn_i), .req_valid_i(req_valid_i),
        .req_ready_o(req_ready_o), .mode_i(mode_i), .pc_base_i(pc_base_i),
        .op_size_i(op_size_i), .addr_reg_sel_i(addr_reg_sel_i),
        .data_reg_sel_i(data_reg_sel_i), .index_reg_sel_i(index_reg_sel_i),
        .index_is_addr_i(index_is_addr_i), .index_long_i(index_long_i),
        .index_scale_i(index_scale_i), .short_disp_8b_i(short_disp_8b_i),
        .short_displacement_i(short_displacement_i),
        .base_disp_long_i(base_disp_long_i),
        .base_displacement_i(base_displacement_i),
        .outer_disp_long_i(outer_disp_long_i),
        .outer_displacement_i(outer_displacement_i), .ext_word_i(ext_word_i),
        .pc_i(pc_i), .data_regs_i(dr), .addr_regs_i(ar),
        .areg_we_o(areg_we_o), .areg_wsel_o(areg_wsel_o),
        .areg_wdata_o(areg_wdata_o), .mem_req_o(mem_req_o),
        .mem_addr_o(mem_addr_o), .mem_ack_i(mem_ack_i),
        .mem_rdata_i(mem_rdata_i), .res_valid_o(res_valid_o),
        .res_is_operand_o(res_is_operand_o), .res_value_o(res_value_o));

    eag_mem_model u_eag_mem_model (
        .clk_i(clk_i), .rstn_i(rstn_i), .mem_req_i(mem_req_o),
        .mem_addr_i(mem_addr_o), .delay_i(mem_delay),
        .mem_ack_o(mem_ack_i), .mem_rdata_o(mem_rdata_i));

    function automatic logic [31:0] nxt();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng;
    endfunction

    function automatic logic [31:0] sx(input logic [15:0] v);
        return {{16{v[15]}}, v};
    endfunction

    function automatic logic [31:0] ptr(input logic [31:0] a);
        return {a[15:0], a[31:16]} ^ 32'ha5a5_a5a5;
    endfunction

    task automatic complete_run();
        if (mismatches == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic cmp_res(input logic [32:0] e, input logic [32:0] g);
        num_checks++;
        if (g !== e) begin
            mismatches++;
            $display("unexpected result at %0t: exp %h got %h", $time, e, g);
        end
    endtask

    task automatic cmp_wr(input logic [34:0] e, input logic [34:0] g);
        num_checks++;
        if (g !== e) begin
            mismatches++;
            $display("unexpected write at %0t: exp %h got %h", $time, e, g);
        end
    endtask

    // one request with random fields; expectation queued before the accept
    task automatic run_one(input logic [3:0] m);
        logic [31:0] r, base, idx, sd, bd, od, sz, msk;
        logic [32:0] e;
        r = nxt();
        @(posedge clk_i);
        mode_i <= m;
        req_valid_i <= 1'b1;
        pc_i <= nxt();
        op_size_i <= (r[1:0] == 2'h3) ? 2'h2 : r[1:0];
        pc_base_i <= r[2] && m != EAG_MODE_POSTINC && m != EAG_MODE_PREDEC;
        addr_reg_sel_i <= r[5:3];
        data_reg_sel_i <= r[8:6];
        index_reg_sel_i <= r[11:9];
        index_is_addr_i <= r[12];
        index_long_i <= r[13];
        index_scale_i <= r[15:14];
        short_disp_8b_i <= r[16];
        base_disp_long_i <= r[17];
        outer_disp_long_i <= r[18];
        mem_delay <= r[21:19];
        r = nxt();
        short_displacement_i <= r[15:0];
        base_displacement_i <= nxt();
        outer_displacement_i <= nxt();
        ext_word_i <= nxt();
        foreach (dr[k]) dr[k] <= nxt();
        @(negedge clk_i);
        base = pc_base_i ? pc_i : ar[addr_reg_sel_i];
        idx = index_is_addr_i ? ar[index_reg_sel_i] : dr[index_reg_sel_i];
        idx = index_long_i ? idx : sx(idx[15:0]);
        idx = idx << index_scale_i;
        sd = short_disp_8b_i ? {{24{short_displacement_i[7]}},
             short_displacement_i[7:0]} : sx(short_displacement_i);
        bd = base_disp_long_i ? base_displacement_i
             : sx(base_displacement_i[15:0]);
        od = outer_disp_long_i ? outer_displacement_i
             : sx(outer_displacement_i[15:0]);
        sz = 32'h0000_0001 << op_size_i;
        msk = (op_size_i == 2'h0) ? 32'h0000_00ff :
              (op_size_i == 2'h1) ? 32'h0000_ffff : 32'hffff_ffff;
        case (m)
            EAG_MODE_DREG:     e = {1'b1, dr[data_reg_sel_i]};
            EAG_MODE_AREG:     e = {1'b1, ar[addr_reg_sel_i]};
            EAG_MODE_IND:      e = {1'b0, base};
            EAG_MODE_POSTINC: begin
                e = {1'b0, base};
                wr_q.push_back({addr_reg_sel_i, base + sz});
            end
            EAG_MODE_PREDEC: begin
                e = {1'b0, base - sz};
                wr_q.push_back({addr_reg_sel_i, base - sz});
            end
            EAG_MODE_DISP:     e = {1'b0, base + sd};
            EAG_MODE_INDEX:    e = {1'b0, base + sd + idx};
            EAG_MODE_MEM_POST: e = {1'b0, ptr(base + bd) + idx + od};
            EAG_MODE_MEM_PRE:  e = {1'b0, ptr(base + bd + idx) + od};
            EAG_MODE_ABS_W:    e = {1'b0, sx(ext_word_i[15:0])};
            EAG_MODE_ABS_L:    e = {1'b0, ext_word_i};
            default:           e = {1'b1, ext_word_i & msk};
        endcase
        res_q.push_back(e);
        for (int t = 0; t < 8 && req_ready_o !== 1'b1; t++) @(negedge clk_i);
        @(posedge clk_i);
        req_valid_i <= 1'b0;
        for (int t = 0; t < 20; t++) begin
            @(negedge clk_i);
            if (res_valid_o === 1'b1) break;
        end
    endtask

    // results and register writes are taken off their queues as they appear
    always @(negedge clk_i) begin
        if (res_valid_o === 1'b1) begin
            cmp_res(res_q.size() != 0 ? res_q.pop_front() : {33{1'bx}},
                    {res_is_operand_o, res_value_o});
        end
        if (areg_we_o === 1'b1) begin
            cmp_wr(wr_q.size() != 0 ? wr_q.pop_front() : {35{1'bx}},
                   {areg_wsel_o, areg_wdata_o});
            ar[areg_wsel_o] = areg_wdata_o;
        end
    end

    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            complete_run();
        end
    end

    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end

    initial begin
        rng = 32'h0000_5bca;
        rstn_i = 1'b0;
        {req_valid_i, mode_i, pc_base_i, op_size_i, addr_reg_sel_i} = '0;
        {data_reg_sel_i, index_reg_sel_i, index_is_addr_i, index_long_i} = '0;
        {index_scale_i, short_disp_8b_i, short_displacement_i} = '0;
        {base_disp_long_i, base_displacement_i, outer_disp_long_i} = '0;
        {outer_displacement_i, ext_word_i, pc_i, mem_delay} = '0;
        foreach (dr[k]) dr[k] = 32'h0000_0000;
        foreach (ar[k]) ar[k] = nxt();
        repeat (6) @(posedge clk_i);
        rstn_i <= 1'b1;
        for (int n = 0; n < 40; n++) begin
            for (int m = 0; m < 12; m++) run_one(m[3:0]);
        end
        repeat (4) @(posedge clk_i);
        if (res_q.size() != 0 || wr_q.size() != 0) mismatches++;
        complete_run();
    end
endmodule // testbench
